// [rlsr_regs.sv]
// Radio link setup register group with decoded settings for the packet engine and RF front end.
// Assumes a same-clock SPI command decoder issuing one-cycle read and write strobes.
`timescale 1ns/1ns
// Behaviour
// - Address width code 01, 10 and 11 select 3, 4 and 5 byte addresses for receive and transmit, 00 is illegal.
// - Below 5 bytes only the low bytes of a stored address are used and the upper ones ignored.
// - The retransmit delay code n waits (n+1) times 250 us, up to 4000 us.
// - The delay runs from the end of one transmission to the start of the next attempt.
// - The retransmit count allows that many retries on a missed acknowledgement, zero disables them.
// - A seven-bit channel field picks the operating channel and bit 7 is reserved.
// - Rate bits 00, 01, 10 give 1 Mbps, 2 Mbps and 250 kbps, and 11 is reserved.
// - With the low-rate bit set the high-rate bit is ignored and the rate is 250 kbps.
// - A test bit forces the PLL lock indication.
// - The two-bit power field sets transmit power, 00 lowest and rising with the code.
// - The registers are reached through SPI read and write commands.
// - Every undefined bit reads as zero; radio setup bit 0 resets to one and reads one until that register is written.
// - Any write to the channel register clears the lost-packet counter.
module rlsr_regs #(
	parameter int STEP_CYC = rlsr_pkg::DELAY_STEP_CYC
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input rlsr_pkg::rlsr_req_t req,
	input wire logic tx_end,
	input wire logic ack_missed,
	input wire logic new_packet,
	input wire logic pll_locked_raw,
	output logic [7:0] rdata,
	output rlsr_pkg::rlsr_cfg_t cfg,
	output logic aw_illegal,
	output logic retry_now,
	output logic retries_exhausted,
	output logic pll_lock,
	output logic [3:0] lost_packet_counter,
	output logic [3:0] retry_counter
);
	logic [7:0] address_width_setup;
	logic [7:0] retransmit_setup;
	logic [7:0] radio_channel;
	logic [7:0] radio_setup;
	logic [7:0] next_rdata;
	logic delay_expired;
	logic retry_pending;
	logic [1:0] rate_bits;
	logic wr_aw;
	logic wr_retr;
	logic wr_ch;
	logic wr_rf;
	logic timer_start;

	// One decoded strobe per register keeps the store and the counter clear in step.
	assign wr_aw = req.wr && req.addr == rlsr_pkg::ADDR_AW;
	assign wr_retr = req.wr && req.addr == rlsr_pkg::ADDR_RETR;
	assign wr_ch = req.wr && req.addr == rlsr_pkg::ADDR_CH;
	assign wr_rf = req.wr && req.addr == rlsr_pkg::ADDR_RF;
	assign timer_start = tx_end && retry_pending;

	// Reserved bits are masked off on every write, so they read zero once written; radio setup bit 0 reads one from reset until then.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			address_width_setup <= rlsr_pkg::RST_AW;
		else if (wr_aw)
			address_width_setup <= req.wdata & rlsr_pkg::MASK_AW;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			retransmit_setup <= rlsr_pkg::RST_RETR;
		else if (wr_retr)
			retransmit_setup <= req.wdata;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			radio_channel <= rlsr_pkg::RST_CH;
		else if (wr_ch)
			radio_channel <= req.wdata & rlsr_pkg::MASK_CH;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			radio_setup <= rlsr_pkg::RST_RF;
		else if (wr_rf)
			radio_setup <= req.wdata & rlsr_pkg::MASK_RF;
	end

	always_comb
	begin
		next_rdata = 8'h00;
		unique case (req.addr)
			rlsr_pkg::ADDR_AW: next_rdata = address_width_setup;
			rlsr_pkg::ADDR_RETR: next_rdata = retransmit_setup;
			rlsr_pkg::ADDR_CH: next_rdata = radio_channel;
			rlsr_pkg::ADDR_RF: next_rdata = radio_setup;
			rlsr_pkg::ADDR_OBSERVE: next_rdata = {lost_packet_counter, retry_counter};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= 8'h00;
		else if (req.rd)
			rdata <= next_rdata;
	end

	assign rate_bits = {radio_setup[5], radio_setup[3]};

	// An illegal width keeps the widest setting so no address byte is silently dropped.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg <= '0;
		end
		else
		begin
			unique case (address_width_setup[1:0])
				rlsr_pkg::AW_3: cfg.addr_bytes <= 3'h3;
				rlsr_pkg::AW_4: cfg.addr_bytes <= 3'h4;
				default: cfg.addr_bytes <= 3'h5;
			endcase
			cfg.delay_code <= retransmit_setup[7:4];
			cfg.retry_count <= retransmit_setup[3:0];
			cfg.channel <= radio_channel[6:0];
			// The reserved rate code 11 falls under the low-rate bit and gives 250 kbps.
			if (rate_bits[1])
				cfg.rate <= rlsr_pkg::RLSR_RATE_250K;
			else if (rate_bits[0])
				cfg.rate <= rlsr_pkg::RLSR_RATE_2M;
			else
				cfg.rate <= rlsr_pkg::RLSR_RATE_1M;
			cfg.power <= radio_setup[2:1];
			cfg.pll_force <= radio_setup[4];
			cfg.carrier_test <= radio_setup[7];
		end
	end

	// The flag only reports the illegal code; the width decode already falls back to five bytes.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			aw_illegal <= 1'b0;
		else
			aw_illegal <= address_width_setup[1:0] == rlsr_pkg::AW_ILLEGAL;
	end

	// The force bit is ORed in so that a test can run the radio with the PLL still unlocked.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pll_lock <= 1'b0;
		else
			pll_lock <= pll_locked_raw | radio_setup[4];
	end

	// The timer is started only while a retry is pending, so a plain end of transmission starts nothing.
	rlsr_timer #(
		.STEP_CYC(STEP_CYC)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(timer_start),
		.delay_code(retransmit_setup[7:4]),
		.expired(delay_expired)
	);

	// A retry is pending after a missed acknowledgement while retries remain.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			retry_pending <= 1'b0;
		else if (new_packet)
			retry_pending <= 1'b0;
		else if (ack_missed)
			retry_pending <= retry_counter < retransmit_setup[3:0];
		else if (delay_expired)
			retry_pending <= 1'b0;
	end

	// A retry is issued at most once per missed acknowledgement, never from a stale pending flag.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			retry_now <= 1'b0;
		else
			retry_now <= delay_expired && retry_pending;
	end

	// Exhaustion is flagged on the miss itself so the packet engine can give up at once.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			retries_exhausted <= 1'b0;
		else
			retries_exhausted <= ack_missed && retry_counter >= retransmit_setup[3:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			retry_counter <= 4'h0;
		else if (new_packet)
			retry_counter <= 4'h0;
		else if (delay_expired && retry_pending && retry_counter != rlsr_pkg::CNT_MAX)
			retry_counter <= retry_counter + 4'h1;
	end

	// The channel write clear wins over a simultaneous loss, as the counter is reset on write.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			lost_packet_counter <= 4'h0;
		else if (wr_ch)
			lost_packet_counter <= 4'h0;
		else if (ack_missed && retry_counter >= retransmit_setup[3:0]
			&& lost_packet_counter != rlsr_pkg::CNT_MAX)
			lost_packet_counter <= lost_packet_counter + 4'h1;
	end
endmodule

// [rlsr_pkg.sv]
// Package for the radio link setup register group: offsets, field layouts, reset values, timing.
// Assumes a single 250 MHz system clock shared with the SPI command decoder that drives it.
package rlsr_pkg;
	localparam logic [7:0] ADDR_AW = 8'h03;
	localparam logic [7:0] ADDR_RETR = 8'h04;
	localparam logic [7:0] ADDR_CH = 8'h05;
	localparam logic [7:0] ADDR_RF = 8'h06;
	localparam logic [7:0] ADDR_OBSERVE = 8'h08;
	localparam logic [7:0] RST_AW = 8'h03;
	localparam logic [7:0] RST_RETR = 8'h03;
	localparam logic [7:0] RST_CH = 8'h02;
	localparam logic [7:0] RST_RF = 8'h0F;
	localparam logic [7:0] MASK_AW = 8'h03;
	localparam logic [7:0] MASK_CH = 8'h7F;
	localparam logic [7:0] MASK_RF = 8'hBE;
	localparam logic [1:0] AW_ILLEGAL = 2'h0;
	localparam logic [1:0] AW_3 = 2'h1;
	localparam logic [1:0] AW_4 = 2'h2;
	localparam logic [1:0] AW_5 = 2'h3;
	localparam int DELAY_STEP_US = 250;
	localparam int CLK_MHZ = 250;
	localparam int DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ;
	localparam logic [3:0] CNT_MAX = 4'hF;
	typedef enum logic [1:0] {
		RLSR_RATE_1M = 2'b00,
		RLSR_RATE_2M = 2'b01,
		RLSR_RATE_250K = 2'b10
	} rlsr_rate_t;
	typedef struct packed {
		logic [2:0] addr_bytes;
		logic [3:0] retry_count;
		logic [3:0] delay_code;
		logic [6:0] channel;
		rlsr_rate_t rate;
		logic [1:0] power;
		logic pll_force;
		logic carrier_test;
	} rlsr_cfg_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rlsr_req_t;
endpackage

// [rlsr_timer.sv]
// Retransmit delay timer: counts whole 250 us steps from end of one transmission.
// Assumes start is a one-cycle pulse at the end of a transmission, on clk_sys.
`timescale 1ns/1ns
module rlsr_timer #(
	parameter int STEP_CYC = rlsr_pkg::DELAY_STEP_CYC
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [3:0] delay_code,
	output logic expired
);
	logic [$clog2(STEP_CYC)-1:0] tick_cnt;
	logic [4:0] steps_left;
	logic step_tick;
	assign step_tick = (tick_cnt == ($clog2(STEP_CYC))'(STEP_CYC - 1));
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tick_cnt <= '0;
		else if (start || step_tick)
			tick_cnt <= '0;
		else if (steps_left != 5'h00)
			tick_cnt <= tick_cnt + 1'b1;
	end
	// Code n waits n+1 steps, so code 0 still gives one full step.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			steps_left <= 5'h00;
		else if (start)
			steps_left <= {1'b0, delay_code} + 5'h01;
		else if (step_tick && steps_left != 5'h00)
			steps_left <= steps_left - 5'h01;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			expired <= 1'b0;
		else
			expired <= !start && step_tick && steps_left == 5'h01;
	end
endmodule

// [rlsr_host.sv]
// Host model: issues one-cycle register strobes.
// Assumes strobes are taken on any rising edge after reset.
`timescale 1ns/1ns
module rlsr_host (
	input wire logic clk_sys,
	output rlsr_pkg::rlsr_req_t req
);
	initial req = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		if (w && a == rlsr_pkg::ADDR_AW)
			d[7:2] = 6'h00;
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_sys);
		req <= '0;
	endtask
endmodule

// [rlsr_asserts.sv]
// Checker of the register group, bound to its top module.
// Assumes cfg follows a write by two edges.
`timescale 1ns/1ns
module rlsr_asserts (
	input wire logic clk_sys,
	input wire logic rst_n,
	input rlsr_pkg::rlsr_req_t req,
	input wire logic ack_missed,
	input wire logic pll_locked_raw,
	input logic [7:0] rdata,
	input rlsr_pkg::rlsr_cfg_t cfg,
	input logic aw_illegal,
	input logic retries_exhausted,
	input logic pll_lock,
	input logic [3:0] lost_packet_counter
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic w_aw = req.wr && req.addr == rlsr_pkg::ADDR_AW;
	wire logic w_rt = req.wr && req.addr == rlsr_pkg::ADDR_RETR;
	wire logic w_ch = req.wr && req.addr == rlsr_pkg::ADDR_CH;
	wire logic w_rf = req.wr && req.addr == rlsr_pkg::ADDR_RF;
	aw_code_a: assert property (w_aw && req.wdata[1:0] != 2'h0 |=> ##1
		cfg.addr_bytes == 3'h2 + 3'($past(req.wdata[1:0], 2))) else $error("width");
	aw_flag_a: assert property (w_aw |=> ##1
		aw_illegal == ($past(req.wdata[1:0], 2) == 2'h0)) else $error("illegal flag");
	retry_setup_a: assert property (w_rt |=> ##1
		{cfg.delay_code, cfg.retry_count} == $past(req.wdata, 2)) else $error("retry setup");
	channel_set_a: assert property (w_ch |=> ##1 cfg.channel == $past(req.wdata[6:0], 2))
		else $error("channel");
	lost_clear_a: assert property (w_ch |=> lost_packet_counter == 4'h0)
		else $error("lost count");
	rate_low_a: assert property (w_rf && req.wdata[5] |=> ##1
		cfg.rate == rlsr_pkg::RLSR_RATE_250K) else $error("low rate");
	rate_high_a: assert property (w_rf && !req.wdata[5] |=> ##1
		cfg.rate == ($past(req.wdata[3], 2) ? rlsr_pkg::RLSR_RATE_2M : rlsr_pkg::RLSR_RATE_1M))
		else $error("high rate");
	power_set_a: assert property (w_rf |=> ##1 cfg.power == $past(req.wdata[2:1], 2))
		else $error("power");
	test_bits_a: assert property (w_rf |=> ##1
		{cfg.carrier_test, cfg.pll_force} == {$past(req.wdata[7], 2), $past(req.wdata[4], 2)})
		else $error("test bits");
	pll_force_a: assert property (w_rf && req.wdata[4] |=> ##1 pll_lock)
		else $error("pll force");
	pll_follow_a: assert property ($past(rst_n) |->
		pll_lock == ($past(pll_locked_raw) || cfg.pll_force)) else $error("pll follow");
	unmapped_read_a: assert property (req.rd && req.addr > 8'h08 |=> rdata == 8'h00)
		else $error("unmapped read");
	retry_exhaust_a: assert property (ack_missed && cfg.retry_count == 4'h0 |->
		##[1:2] retries_exhausted) else $error("no retries");
	cover property (w_ch);
	cover property (retries_exhausted);
	cover property (aw_illegal);
	cover property (w_rf && req.wdata[4]);
endmodule
bind rlsr_regs rlsr_asserts chk (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
	.ack_missed(ack_missed), .pll_locked_raw(pll_locked_raw), .rdata(rdata), .cfg(cfg),
	.aw_illegal(aw_illegal),
	.retries_exhausted(retries_exhausted), .pll_lock(pll_lock),
	.lost_packet_counter(lost_packet_counter));

// [radio_link_setup_registers_tb_top.sv]
// Self-checking bench: host model drives strobes, reads are checked from a queue.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ns
module radio_link_setup_registers_tb_top;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic tx_end = 1'b0;
	logic ack_missed = 1'b0;
	logic new_packet = 1'b0;
	logic pll_raw = 1'b0;
	logic rd_d = 1'b0;
	integer seed = 32'hBB1D;
	int fail_count = 0;
	int n_tests = 0;
	int cyc;
	int k;
	logic [7:0] d;
	logic [7:0] exp_q[$];
	logic [7:0] masks[4] = '{rlsr_pkg::MASK_AW, 8'hFF, rlsr_pkg::MASK_CH, rlsr_pkg::MASK_RF};
	logic [7:0] rdata;
	logic [3:0] retries;
	logic rnow;
	rlsr_pkg::rlsr_req_t req;
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) rd_d <= req.rd;
	always @(posedge clk_sys) pll_raw <= 1'($random(seed));
	rlsr_host host (.clk_sys(clk_sys), .req(req));
	rlsr_regs #(.STEP_CYC(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .tx_end(tx_end),
		.ack_missed(ack_missed), .new_packet(new_packet), .pll_locked_raw(pll_raw), .rdata(rdata),
		.cfg(), .aw_illegal(), .retry_now(rnow), .retries_exhausted(), .pll_lock(),
		.lost_packet_counter(), .retry_counter(retries));
	task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
		n_tests++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Pulse mask order is tx_end, ack_missed, new_packet.
	task automatic pulse(input logic [2:0] m);
		@(posedge clk_sys);
		{tx_end, ack_missed, new_packet} <= m;
		@(posedge clk_sys);
		{tx_end, ack_missed, new_packet} <= 3'b000;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.xfer(1'b0, a, 8'h00);
	endtask
	// Reads are judged half a cycle after the answer edge, clear of the next update.
	always @(negedge clk_sys)
		if (rd_d)
			check("rdata", exp_q.pop_front(), rdata);
	initial
	begin
		#20000;
		fail_count++;
		close_out();
	end
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'h03, 8'h03);
		rd(8'h04, 8'h03);
		rd(8'h05, 8'h02);
		rd(8'h06, 8'h0F);
		rd(8'h1F, 8'h00);
		$display("reset values done");
		repeat (30)
		begin
			k = $unsigned($random(seed)) % 4;
			d = 8'($random(seed));
			host.xfer(1'b1, 8'h03 + 8'(k), d);
			host.xfer(1'b1, 8'h2A, 8'hFF);
			rd(8'h03 + 8'(k), d & masks[k]);
		end
		$display("write readback done");
		host.xfer(1'b1, 8'h04, 8'h20);
		pulse(3'b001);
		pulse(3'b010);
		repeat (4) @(posedge clk_sys);
		rd(8'h08, 8'h10);
		host.xfer(1'b1, 8'h05, 8'h11);
		rd(8'h08, 8'h00);
		$display("lost counter done");
		host.xfer(1'b1, 8'h04, 8'h22);
		pulse(3'b001);
		pulse(3'b010);
		pulse(3'b100);
		cyc = 0;
		do
		begin
			@(negedge clk_sys);
			cyc++;
		end
		while (rnow !== 1'b1 && cyc < 100);
		// The two extra cycles are the timer's expiry flag and the registered retry pulse.
		check("retry delay", 8'((2 + 1) * 4 + 2), 8'(cyc));
		@(negedge clk_sys);
		check("retry count", 8'h01, {4'h0, retries});
		$display("retransmit done");
		repeat (4) @(posedge clk_sys);
		close_out();
	end
endmodule
